// ### core/sls_pin_sync.v
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes clk_sys_i is the only clock; rst_i is synchronous, active high.
`timescale 1ns/10ps
`include "sls_map.vh"

module sls_pin_sync (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // Pin side
    input wire pin_i,
    // Filtered level and edges
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

reg meta_r;
reg s2_r;
reg s3_r;
reg level_r;

////////////////////////////////////////////////////////////////////////
// Stage 1 is read only by stage 2; level moves when stages 2 and 3 agree
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        meta_r <= 1'h0;
        s2_r <= 1'h0;
        s3_r <= 1'h0;
        level_r <= 1'h0;
    end else begin
        meta_r <= pin_i;
        s2_r <= meta_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

wire level_nxt;
assign level_nxt = (s2_r == s3_r) ? s3_r : level_r;
assign level_o = level_r;
assign rise_o = level_nxt & ~level_r;
assign fall_o = ~level_nxt & level_r;

endmodule // sls_pin_sync

// ### core/sls_shift_latch.v
// Serial-in shift register, storage latch and gated open-drain sinks.
// Assumes all pin inputs are asynchronous to clk_sys_i and are
// oversampled; pin edges must be several system clocks apart.
//
// Contract
// - Eight-bit shift register feeds eight-bit storage register.
// - Shift-clock rising edge samples serial input and shifts one place.
// - Latch-clock rising edge copies all shift stages into storage.
// - Clear low zeroes shift, storage and output buffer.
// - Storage reaches output buffer only while clear is high.
// - Output enable high forces all buffer bits low, sinks off.
// - Output enable low makes buffer follow storage without clock edge.
// - Sink output is off for buffer zero and sinks for one.
// - Cascade output updates on falling shift-clock edge.
// - Cascade output presents the last shift stage.
`timescale 1ns/10ps
`include "sls_map.vh"

module sls_shift_latch (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // Serial control pins
    input wire shift_clock_i,
    input wire latch_clock_i,
    input wire clear_n_i,
    input wire out_enable_n_i,
    input wire shift_data_in_i,
    // Cascade output
    output wire cascade_data_out_o,
    // Open-drain sinks: output low level, enable high while sinking
    output wire [`SLS_MSB:0] sink_out_o,
    output wire [`SLS_MSB:0] sink_out_oe_o
);

wire sck_rise;
wire sck_fall;
wire lck_rise;
wire clr_n_lvl;
wire oe_n_lvl;
wire sdi_lvl;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
sls_pin_sync u_sync_sck (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(shift_clock_i),
    .level_o(),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
);

sls_pin_sync u_sync_lck (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(latch_clock_i),
    .level_o(),
    .rise_o(lck_rise),
    .fall_o()
);

sls_pin_sync u_sync_clr (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(clear_n_i),
    .level_o(clr_n_lvl),
    .rise_o(),
    .fall_o()
);

sls_pin_sync u_sync_oe (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(out_enable_n_i),
    .level_o(oe_n_lvl),
    .rise_o(),
    .fall_o()
);

// Same synchroniser as the clock, but edges lead level_o by one cycle, so data needs one cycle of setup
sls_pin_sync u_sync_sdi (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(shift_data_in_i),
    .level_o(sdi_lvl),
    .rise_o(),
    .fall_o()
);

////////////////////////////////////////////////////////////////////////
// Next-value helpers

// One shift step: the new bit enters stage 0 and older bits move up
function [`SLS_MSB:0] sls_shift_step;
    input [`SLS_MSB:0] cur;
    input din;
    begin
        sls_shift_step = {cur[`SLS_MSB-1:0], din};
    end
endfunction

// Far end of the shift register, passed on to the next device
function sls_far_stage;
    input [`SLS_MSB:0] cur;
    begin
        sls_far_stage = cur[`SLS_MSB];
    end
endfunction

// Buffer gating: clear or a high enable empties it, else storage passes
function [`SLS_MSB:0] sls_gate;
    input [`SLS_MSB:0] stored;
    input clr;
    input en_n;
    begin
        if (clr || en_n) begin
            sls_gate = `SLS_ZERO;
        end else begin
            sls_gate = stored;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Shift, storage, buffer and cascade registers
reg [`SLS_MSB:0] shift_r;
reg [`SLS_MSB:0] shift_nxt;
reg [`SLS_MSB:0] store_r;
reg [`SLS_MSB:0] store_nxt;
reg [`SLS_MSB:0] obuf_r;
reg [`SLS_MSB:0] obuf_nxt;
reg cascade_r;
reg cascade_nxt;
wire clear_act;

// Reset and a low clear pin both empty every register
assign clear_act = rst_i | ~clr_n_lvl;

always @* begin
    shift_nxt = shift_r;
    if (clear_act) begin
        shift_nxt = `SLS_ZERO;
    end else if (sck_rise) begin
        shift_nxt = sls_shift_step(shift_r, sdi_lvl);
    end
end

always @* begin
    store_nxt = store_r;
    if (clear_act) begin
        store_nxt = `SLS_ZERO;
    end else if (lck_rise) begin
        store_nxt = shift_r;
    end
end

// Cascade moves on the falling shift edge for extra downstream hold
always @* begin
    cascade_nxt = cascade_r;
    if (clear_act) begin
        cascade_nxt = 1'h0;
    end else if (sck_fall) begin
        cascade_nxt = sls_far_stage(shift_r);
    end
end

// One register stage stands in for the transparent buffer path
always @* begin
    obuf_nxt = sls_gate(store_r, clear_act, oe_n_lvl);
end

always @(posedge clk_sys_i) begin
    shift_r <= shift_nxt;
end

always @(posedge clk_sys_i) begin
    store_r <= store_nxt;
end

always @(posedge clk_sys_i) begin
    cascade_r <= cascade_nxt;
end

always @(posedge clk_sys_i) begin
    obuf_r <= obuf_nxt;
end

////////////////////////////////////////////////////////////////////////
// Outputs
assign cascade_data_out_o = cascade_r;
assign sink_out_o = `SLS_ZERO;
assign sink_out_oe_o = obuf_r;

endmodule // sls_shift_latch

// ### shared/sls_map.vh
// Constants for the serial LED shift-and-latch block.
// Assumes inclusion by bare name from the core design files.
`ifndef SLS_MAP_VH
`define SLS_MAP_VH

`define SLS_WIDTH 8
`define SLS_MSB 7
`define SLS_ZERO 8'h00
`define SLS_SYNC_DEPTH 3

`endif

// ### testbench/sls_host.sv
// Host model driving the serial pins.
// Assumes clk_i is the system clock; pins move on its falling edge.
`timescale 1ns/10ps
module sls_host (
    input wire clk_i,
    output reg sck_o = 0,
    output reg lck_o = 0,
    output reg sd_o = 0
);
task w;
    repeat (4) @(negedge clk_i);
endtask
// Shift clock idles low; data is inverted once hold runs out
task send(input [7:0] b);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
        sd_o = b[i];
        w;
        sck_o = 1;
        w;
        sck_o = 0;
        w;
        sd_o = ~b[i];
        w;
    end
endtask
task latch;
    w;
    lck_o = 1;
    w;
    lck_o = 0;
    w;
endtask
endmodule // sls_host

// ### testbench/sls_shift_latch_assertions.sv
// Port checker for the shift latch.
// Assumes binding to sls_shift_latch.
`timescale 1ns/10ps
module sls_chk (
    input wire clk_sys_i, rst_i, shift_clock_i, latch_clock_i,
    input wire clear_n_i, out_enable_n_i, shift_data_in_i,
    input wire cascade_data_out_o,
    input wire [7:0] sink_out_o, sink_out_oe_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
sequence s_quiet;
    ($stable(latch_clock_i) && $stable(out_enable_n_i) && clear_n_i) [*6];
endsequence
chk_sink_level: assert property (sink_out_o == 8'h00) else $error("lvl");
chk_off_forced: assert property (out_enable_n_i [*6] |->
    sink_out_oe_o == 8'h00) else $error("off");
chk_clear_all: assert property (!clear_n_i [*6] |->
    !sink_out_oe_o && !cascade_data_out_o) else $error("clr");
chk_sink_hold: assert property (s_quiet |->
    $stable(sink_out_oe_o)) else $error("hold");
chk_casc_hold: assert property (
    ($stable(shift_clock_i) && clear_n_i) [*6]
    |-> $stable(cascade_data_out_o)) else $error("casc");
chk_casc_fall: assert property ($rose(shift_clock_i) && clear_n_i |=>
    $stable(cascade_data_out_o) [*5]) else $error("rise");
chk_needs_en: assert property (|sink_out_oe_o |->
    !$past(out_enable_n_i, 5)) else $error("en");
chk_needs_clr: assert property (|sink_out_oe_o |->
    $past(clear_n_i, 5)) else $error("nclr");
endmodule // sls_chk
bind sls_shift_latch sls_chk u_sls_chk (.*);

// ### testbench/test_sls_shift_latch.sv
// Bench for the shift latch.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
module test_sls_shift_latch;
reg clk_sys_i = 0, rst_i = 1, clr_n = 1, en_n = 0;
wire sck, lck, sd, cdo;
wire [7:0] so, oe;
integer error_cnt = 0, total_checks = 0;
always #12.5 clk_sys_i = ~clk_sys_i;
sls_host u_sls_host (.clk_i(clk_sys_i), .sck_o(sck), .lck_o(lck),
    .sd_o(sd));
sls_shift_latch u_sls_shift_latch (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .shift_clock_i(sck), .latch_clock_i(lck), .clear_n_i(clr_n),
    .out_enable_n_i(en_n), .shift_data_in_i(sd),
    .cascade_data_out_o(cdo), .sink_out_o(so), .sink_out_oe_o(oe));
task chk(input [63:0] n, input [7:0] s, e);
    total_checks = total_checks + 1;
    if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s exp %h got %h", n, e, s);
    end
endtask
task w;
    repeat (8) @(negedge clk_sys_i);
endtask
task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task t_shift;
    u_sls_host.send(8'h3C);
    u_sls_host.latch;
    u_sls_host.send(8'hA5);
    chk("hold", oe, 8'h3C);
    u_sls_host.latch;
    chk("sink", oe, 8'hA5);
    chk("casc", {7'h00, cdo}, 8'h01);
endtask
task t_gate;
    en_n = 1;
    w;
    chk("off", oe, 8'h00);
    en_n = 0;
    w;
    chk("on", oe, 8'hA5);
endtask
// Asymmetric pattern exposes bit order and the far stage
task t_cascade;
    u_sls_host.send(8'h80);
    chk("far", {7'h00, cdo}, 8'h01);
    u_sls_host.latch;
    chk("order", oe, 8'h80);
    chk("lvl", so, 8'h00);
endtask
task t_clear;
    clr_n = 0;
    w;
    chk("clr", oe | {7'h00, cdo}, 8'h00);
    clr_n = 1;
    u_sls_host.latch;
    chk("empty", oe, 8'h00);
endtask
initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_i = 0;
    w;
    t_shift;
    t_gate;
    t_cascade;
    t_clear;
    complete_run;
end
endmodule // test_sls_shift_latch
